/* File: irq_status_pkg.sv */
// constants for the event flag and mask register block
`default_nettype none
package irq_status_pkg;
	localparam logic [7:0] IDX_EVENT_FLAGS    = 8'hFE;
	localparam logic [7:0] IDX_EVENT_MASK     = 8'hFF;
	localparam logic [7:0] IDX_IRQ_PIN_CTRL   = 8'h39;
	localparam logic [7:0] IDX_RD_PTR_HIGH    = 8'hF5;
	localparam int         NUM_EVENTS         = 6;
	localparam int         BIT_BUS_WIDTH      = 7;
	localparam int         BIT_RESERVED       = 6;
	localparam int         BIT_LINK_CHANGE    = 5;
	localparam int         BIT_TX_UNDERRUN    = 4;
	localparam int         BIT_RX_CNT_WRAP    = 3;
	localparam int         BIT_RX_OVERFLOW    = 2;
	localparam int         BIT_TX_DONE        = 1;
	localparam int         BIT_RX_DONE        = 0;
	localparam int         BIT_AUTOWRAP       = 7;
	localparam int         BIT_IRQ_POLARITY   = 0;
	localparam int         BIT_IRQ_OPEN_DRAIN = 1;
	localparam logic [7:0] MASK_WRITABLE      = 8'hBF;
	localparam logic [7:0] AUTOWRAP_PTR_HIGH  = 8'h0C;
	localparam logic [7:0] REG_RESET          = 8'h00;
	localparam logic [5:0] FLAGS_RESET        = 6'h00;
	localparam logic [1:0] PIN_CTRL_RESET     = 2'h0;
endpackage
`default_nettype wire

/* File: strap_sync.sv */
// three-stage synchroniser that accepts a level once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module strap_sync (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic async_i,
	output var  logic level_o
);
	logic stage1_ff;
	logic stage2_ff;
	logic stage3_ff;

	// first stage feeds only the second one
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage1_ff <= 1'b0;
			stage2_ff <= 1'b0;
			stage3_ff <= 1'b0;
		end else begin
			stage1_ff <= async_i;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// a change counts only once two settled stages agree
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level_o <= 1'b0;
		end else if (stage2_ff == stage3_ff) begin
			level_o <= stage3_ff;
		end
	end
endmodule
`default_nettype wire

/* File: ethernet_irq_status_mask.sv */
// event flags, enable mask, irq pin shaping and pointer wrap control
//
// What this block does
// - status bit 7 reads the strapped bus width: 0 is 16-bit, 1 is 8-bit
// - link change sets status bit 5; writing one clears it
// - transmit under-run sets status bit 4; writing one clears it
// - receive overflow counter overflow sets status bit 3; write one clears
// - receive overflow sets status bit 2; writing one clears it
// - packet sent sets status bit 1, write-one clear, gated by mask bit 1
// - packet received sets status bit 0, write-one clear, gated by mask bit 0
// - mask bit 5 enables the link change interrupt
// - mask bit 4 enables the transmit under-run interrupt
// - mask bit 3 enables the counter overflow interrupt
// - mask bit 2 enables the receive overflow interrupt
// - mask bit 7 makes the sram pointers wrap to the start address
// - setting the wrap enable loads read pointer high byte with 0Ch
// - bit 6 of both registers is reserved; reset clears flags and enables
// - polarity control bit: one gives active low irq, zero active high
// - type control bit: one gives open drain irq, zero driven output
`timescale 1ns/1ps
`default_nettype none
module ethernet_irq_status_mask (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	input  wire logic       sw_reset_i,
	input  wire logic       bus_width_strap_i,
	input  wire logic       index_wr_i,
	input  wire logic       data_wr_i,
	input  wire logic       data_rd_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       link_change_evt_i,
	input  wire logic       tx_underrun_evt_i,
	input  wire logic       rx_cnt_wrap_evt_i,
	input  wire logic       rx_overflow_evt_i,
	input  wire logic       tx_done_evt_i,
	input  wire logic       rx_done_evt_i,
	output var  logic [7:0] rdata_o,
	output var  logic       irq_o,
	output var  logic       irq_oe_o,
	output var  logic       pointer_autowrap_o,
	output var  logic [7:0] read_pointer_high_byte_o
);
	logic [7:0] index_ff;
	logic [5:0] flags_ff;
	logic [7:0] mask_ff;
	logic [1:0] pin_ctrl_ff;
	logic [7:0] ptr_high_ff;
	logic       bus_width_flag;
	logic       bus_width_ff;
	logic [5:0] events;
	logic [5:0] clear_req;
	logic       pending;
	logic       wr_flags;
	logic       wr_mask;
	logic       wr_pin_ctrl;
	logic       wr_ptr_high;
	logic [7:0] nxt_rdata;
	logic       nxt_irq;
	logic       nxt_irq_oe;

	strap_sync u_width_sync (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.async_i   (bus_width_strap_i),
		.level_o   (bus_width_flag)
	);

	assign events = {link_change_evt_i, tx_underrun_evt_i, rx_cnt_wrap_evt_i,
			 rx_overflow_evt_i, tx_done_evt_i, rx_done_evt_i};

	assign wr_flags    = data_wr_i && (index_ff == irq_status_pkg::IDX_EVENT_FLAGS);
	assign wr_mask     = data_wr_i && (index_ff == irq_status_pkg::IDX_EVENT_MASK);
	assign wr_pin_ctrl = data_wr_i
			     && (index_ff == irq_status_pkg::IDX_IRQ_PIN_CTRL);
	assign wr_ptr_high = data_wr_i
			     && (index_ff == irq_status_pkg::IDX_RD_PTR_HIGH);
	assign clear_req   = wr_flags ? wdata_i[5:0] : 6'h00;

	// index port selects which register the data strobes reach
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			index_ff <= irq_status_pkg::REG_RESET;
		end else if (index_wr_i) begin
			index_ff <= wdata_i;
		end
	end

	// strap level held as a read-only status bit
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_width_ff <= 1'b0;
		end else begin
			bus_width_ff <= bus_width_flag;
		end
	end

	// per-event sticky flag; a new event beats a same-cycle clear
	for (genvar k = 0; k < irq_status_pkg::NUM_EVENTS; k++) begin : g_flag
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				flags_ff[k] <= 1'b0;
			end else if (sw_reset_i) begin
				flags_ff[k] <= 1'b0;
			end else if (events[k]) begin
				flags_ff[k] <= 1'b1;
			end else if (clear_req[k]) begin
				flags_ff[k] <= 1'b0;
			end
		end
	end

	// reserved bit 6 is never stored so it always reads zero
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_ff <= irq_status_pkg::REG_RESET;
		end else if (sw_reset_i) begin
			mask_ff <= irq_status_pkg::REG_RESET;
		end else if (wr_mask) begin
			mask_ff <= wdata_i & irq_status_pkg::MASK_WRITABLE;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_ctrl_ff <= irq_status_pkg::PIN_CTRL_RESET;
		end else if (sw_reset_i) begin
			pin_ctrl_ff <= irq_status_pkg::PIN_CTRL_RESET;
		end else if (wr_pin_ctrl) begin
			pin_ctrl_ff <= wdata_i[1:0];
		end
	end

	// enabling the wrap forces the read pointer into the rx region
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_high_ff <= irq_status_pkg::REG_RESET;
		end else if (wr_mask && wdata_i[irq_status_pkg::BIT_AUTOWRAP]) begin
			ptr_high_ff <= irq_status_pkg::AUTOWRAP_PTR_HIGH;
		end else if (wr_ptr_high) begin
			ptr_high_ff <= wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pointer_autowrap_o       <= 1'b0;
			read_pointer_high_byte_o <= irq_status_pkg::REG_RESET;
		end else begin
			pointer_autowrap_o <= mask_ff[irq_status_pkg::BIT_AUTOWRAP];
			read_pointer_high_byte_o <= ptr_high_ff;
		end
	end

	// only event bits meet their enables; bit 7 of the mask is not an enable
	assign pending = |(flags_ff & mask_ff[5:0]);

	// open drain can only pull low, so it releases whenever the irq level is high
	always_comb begin
		nxt_irq    = pending ^ pin_ctrl_ff[irq_status_pkg::BIT_IRQ_POLARITY];
		nxt_irq_oe = 1'b1;
		if (pin_ctrl_ff[irq_status_pkg::BIT_IRQ_OPEN_DRAIN]) begin
			nxt_irq_oe = !nxt_irq;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o    <= 1'b0;
			irq_oe_o <= 1'b1;
		end else begin
			irq_o    <= nxt_irq;
			irq_oe_o <= nxt_irq_oe;
		end
	end

	always_comb begin
		nxt_rdata = irq_status_pkg::REG_RESET;
		unique case (index_ff)
			irq_status_pkg::IDX_EVENT_FLAGS: begin
				nxt_rdata = {bus_width_ff, 1'b0, flags_ff};
			end
			irq_status_pkg::IDX_EVENT_MASK: begin
				nxt_rdata = mask_ff;
			end
			irq_status_pkg::IDX_IRQ_PIN_CTRL: begin
				nxt_rdata = {6'h00, pin_ctrl_ff};
			end
			irq_status_pkg::IDX_RD_PTR_HIGH: begin
				nxt_rdata = ptr_high_ff;
			end
			default: begin
				nxt_rdata = irq_status_pkg::REG_RESET;
			end
		endcase
	end

	// reads have no side effect; flags clear only on a written one, a software reset or a hardware reset
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= irq_status_pkg::REG_RESET;
		end else if (data_rd_i) begin
			rdata_o <= nxt_rdata;
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_LINK_SET: assert property (
		link_change_evt_i && !sw_reset_i
		|=> flags_ff[irq_status_pkg::BIT_LINK_CHANGE] [*2]
		    or (sw_reset_i || clear_req[irq_status_pkg::BIT_LINK_CHANGE]))
		else $error("link change flag not held after event");

	AST_UNDERRUN_W1C: assert property (
		wr_flags && wdata_i[irq_status_pkg::BIT_TX_UNDERRUN]
		&& !tx_underrun_evt_i
		|=> !flags_ff[irq_status_pkg::BIT_TX_UNDERRUN])
		else $error("under-run flag survived write-one clear");

	AST_SET_BEATS_CLEAR: assert property (
		wr_flags && wdata_i[irq_status_pkg::BIT_RX_CNT_WRAP]
		&& rx_cnt_wrap_evt_i && !sw_reset_i
		|=> flags_ff[irq_status_pkg::BIT_RX_CNT_WRAP])
		else $error("event lost against same-cycle clear");

	AST_ZERO_KEEPS: assert property (
		wr_flags && !wdata_i[irq_status_pkg::BIT_RX_OVERFLOW] && !sw_reset_i
		&& flags_ff[irq_status_pkg::BIT_RX_OVERFLOW]
		|=> flags_ff[irq_status_pkg::BIT_RX_OVERFLOW])
		else $error("writing zero cleared a flag");

	AST_MASKED_QUIET: assert property (
		(flags_ff & mask_ff[5:0]) == 6'h00 && !pin_ctrl_ff[0]
		&& $stable(pin_ctrl_ff) |=> !irq_o)
		else $error("irq active with no enabled flag");

	AST_ENABLED_FIRES: assert property (
		rx_done_evt_i && mask_ff[irq_status_pkg::BIT_RX_DONE]
		&& !sw_reset_i && !wr_mask && !wr_pin_ctrl && !pin_ctrl_ff[0]
		|=> ##1 irq_o)
		else $error("enabled receive event raised no irq");

	AST_AUTOWRAP_LOAD: assert property (
		wr_mask && wdata_i[irq_status_pkg::BIT_AUTOWRAP] && !sw_reset_i
		|=> ##1 read_pointer_high_byte_o == irq_status_pkg::AUTOWRAP_PTR_HIGH
		    && pointer_autowrap_o)
		else $error("wrap enable did not load pointer high byte");

	AST_SW_RESET: assert property (
		sw_reset_i |=> flags_ff == irq_status_pkg::FLAGS_RESET
		&& mask_ff == irq_status_pkg::REG_RESET)
		else $error("software reset left flags or enables");

	// the pointer byte is a full data byte, so only flags and mask count
	AST_RESERVED_ZERO: assert property (
		data_rd_i && (index_ff == irq_status_pkg::IDX_EVENT_FLAGS
		|| index_ff == irq_status_pkg::IDX_EVENT_MASK)
		|=> !rdata_o[irq_status_pkg::BIT_RESERVED])
		else $error("reserved bit read as one");

	AST_WIDTH_READ: assert property (
		data_rd_i && index_ff == irq_status_pkg::IDX_EVENT_FLAGS
		|=> rdata_o[irq_status_pkg::BIT_BUS_WIDTH] == $past(bus_width_ff))
		else $error("bus width bit mismatch");

	AST_OPEN_DRAIN_IDLE: assert property (
		pin_ctrl_ff == 2'h3 && $stable(pin_ctrl_ff) && !pending
		|=> irq_o && !irq_oe_o)
		else $error("open drain irq driven while idle");

	AST_TX_DONE_SET: assert property (
		tx_done_evt_i && !sw_reset_i
		|=> flags_ff[irq_status_pkg::BIT_TX_DONE])
		else $error("packet sent event did not set its flag");

	AST_OVERFLOW_SET: assert property (
		rx_overflow_evt_i && !sw_reset_i
		|=> flags_ff[irq_status_pkg::BIT_RX_OVERFLOW])
		else $error("receive overflow event did not set its flag");

	AST_PENDING_DRIVES: assert property (
		pending && !pin_ctrl_ff[irq_status_pkg::BIT_IRQ_POLARITY]
		|=> irq_o)
		else $error("enabled pending flag left irq inactive");

	AST_DIRECT_DRIVE: assert property (
		!pin_ctrl_ff[irq_status_pkg::BIT_IRQ_OPEN_DRAIN] |=> irq_oe_o)
		else $error("direct drive irq pin not enabled");

	AST_AUTOWRAP_FOLLOWS: assert property (
		wr_mask && !sw_reset_i
		|=> ##1 pointer_autowrap_o
		    == $past(wdata_i[irq_status_pkg::BIT_AUTOWRAP], 2))
		else $error("wrap enable output does not follow mask bit");

	COV_IRQ_RAISED: cover property (!irq_o ##1 irq_o);
	COV_SW_RESET_FLAGS: cover property (sw_reset_i && flags_ff != 6'h00);
	COV_SET_AND_CLEAR: cover property (link_change_evt_i && wr_flags);
	COV_AUTOWRAP: cover property (wr_mask && wdata_i[7]);
	COV_OPEN_DRAIN_LOW: cover property (irq_oe_o && !irq_o && pin_ctrl_ff[1]);
endmodule
`default_nettype wire

/* File: host_bus_model.sv */
// host processor model for the index and data port
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	input  wire logic       clk_sys_i,
	output var  logic       index_wr_o,
	output var  logic       data_wr_o,
	output var  logic       data_rd_o,
	output var  logic [7:0] wdata_o
);
	initial begin
		index_wr_o = 1'b0;
		data_wr_o = 1'b0;
		data_rd_o = 1'b0;
		wdata_o = 8'h00;
	end
	// index first, data strobe next cycle, never both at once
	task automatic sel(input logic [7:0] idx);
		@(posedge clk_sys_i);
		index_wr_o <= 1'b1;
		wdata_o <= idx;
		@(posedge clk_sys_i);
		index_wr_o <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		sel(idx);
		data_wr_o <= 1'b1;
		wdata_o <= val;
		@(posedge clk_sys_i);
		data_wr_o <= 1'b0;
		// released bus must not keep the last value
		wdata_o <= ~val;
	endtask
	task automatic rd(input logic [7:0] idx);
		sel(idx);
		data_rd_o <= 1'b1;
		wdata_o <= ~idx;
		@(posedge clk_sys_i);
		data_rd_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the event flag and mask block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       clk_sys_i;
	logic       rst_n_i;
	logic       sw_reset_i;
	logic       idx_wr;
	logic       d_wr;
	logic       d_rd;
	logic       rd_pend;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] ptr_hi;
	logic [5:0] evt;
	logic [5:0] m;
	logic [5:0] c;
	logic       irq;
	logic       irq_oe;
	logic       autowrap;
	logic       e;
	logic       strap;
	logic [7:0] exp_q[$];
	int         n_mismatch;
	int         samples_checked;
	int         seed;

	host_bus_model host (.clk_sys_i(clk_sys_i), .index_wr_o(idx_wr),
		.data_wr_o(d_wr), .data_rd_o(d_rd), .wdata_o(wdata));

	ethernet_irq_status_mask dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.sw_reset_i(sw_reset_i), .bus_width_strap_i(strap),
		.index_wr_i(idx_wr), .data_wr_i(d_wr), .data_rd_i(d_rd),
		.wdata_i(wdata), .link_change_evt_i(evt[5]),
		.tx_underrun_evt_i(evt[4]), .rx_cnt_wrap_evt_i(evt[3]),
		.rx_overflow_evt_i(evt[2]), .tx_done_evt_i(evt[1]),
		.rx_done_evt_i(evt[0]), .rdata_o(rdata), .irq_o(irq),
		.irq_oe_o(irq_oe), .pointer_autowrap_o(autowrap),
		.read_pointer_high_byte_o(ptr_hi));

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		exp_q.push_back(exp);
		host.rd(idx);
	endtask
	task automatic pulse(input logic [5:0] v);
		@(posedge clk_sys_i);
		evt <= v;
		@(posedge clk_sys_i);
		evt <= 6'h00;
	endtask
	// irq and pointer outputs lag the register by one more cycle
	task automatic settle;
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask

	always @(posedge clk_sys_i) rd_pend <= d_rd;
	always @(negedge clk_sys_i) begin
		if (rd_pend === 1'b1)
			check("rdata", rdata, exp_q.pop_front());
	end

	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// guards against a hung sequence
	initial begin
		#2000000;
		n_mismatch++;
		summarize;
	end

	initial begin
		rst_n_i = 1'b0;
		sw_reset_i = 1'b0;
		evt = 6'h00;
		strap = 1'b1;
		seed = 2;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		// strap flag needs a few edges through the synchroniser
		repeat (6) @(posedge clk_sys_i);
		rd(8'hFE, 8'h80);
		rd(8'hFF, 8'h00);
		rd(8'h10, 8'h00);
		@(negedge clk_sys_i);
		check("ptr high", ptr_hi, 8'h00);
		check("autowrap", {7'h00, autowrap}, 8'h00);
		host.wr(8'hFF, 8'hFF);
		rd(8'hFF, 8'hBF);
		settle;
		check("autowrap", {7'h00, autowrap}, 8'h01);
		check("ptr high", ptr_hi, 8'h0C);
		for (int b = 0; b < 6; b++) begin
			pulse(6'h01 << b);
			rd(8'hFE, 8'h80 | (8'h01 << b));
			settle;
			check("irq set", {7'h00, irq}, 8'h01);
			host.wr(8'hFE, 8'h01 << b);
			rd(8'hFE, 8'h80);
			settle;
			check("irq clr", {7'h00, irq}, 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			m = 6'($random(seed));
			c = 6'($random(seed));
			host.wr(8'hFF, {2'b00, m});
			pulse(6'h3F);
			host.wr(8'hFE, {2'b00, c});
			rd(8'hFE, {2'b10, ~c});
			settle;
			e = |(~c & m);
			check("irq mask", {7'h00, irq}, {7'h00, e});
			host.wr(8'hFE, 8'h3F);
		end
		check("autowrap", {7'h00, autowrap}, 8'h00);
		// event and write-one clear land on one edge: the event wins
		fork
			host.wr(8'hFE, 8'h28);
			begin
				repeat (2) @(posedge clk_sys_i);
				evt <= 6'h28;
				@(posedge clk_sys_i);
				evt <= 6'h00;
			end
		join
		rd(8'hFE, 8'hA8);
		host.wr(8'hFE, 8'h28);
		rd(8'hFE, 8'h80);
		host.wr(8'hFF, 8'h01);
		for (int pd = 0; pd < 2; pd++) begin
			if (pd == 1)
				pulse(6'h01);
			for (int p = 0; p < 4; p++) begin
				host.wr(8'h39, 8'(p));
				rd(8'h39, 8'(p));
				settle;
				e = pd[0] ^ p[0];
				check("irq pol", {7'h00, irq}, {7'h00, e});
				check("irq oe", {7'h00, irq_oe}, {7'h00, p[1] ? ~e : 1'b1});
			end
		end
		host.wr(8'hF5, 8'h5A);
		rd(8'hF5, 8'h5A);
		host.wr(8'hFF, 8'hFF);
		rd(8'hF5, 8'h0C);
		@(posedge clk_sys_i);
		sw_reset_i <= 1'b1;
		@(posedge clk_sys_i);
		sw_reset_i <= 1'b0;
		rd(8'hFF, 8'h00);
		rd(8'hFE, 8'h80);
		rd(8'h39, 8'h00);
		settle;
		check("irq rst", {7'h00, irq}, 8'h00);
		check("oe rst", {7'h00, irq_oe}, 8'h01);
		// a 16-bit strap must read back as zero once synchronised
		@(posedge clk_sys_i);
		strap <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		rd(8'hFE, 8'h00);
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		@(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(8'hFF, 8'h00);
		settle;
		check("autowrap", {7'h00, autowrap}, 8'h00);
		repeat (3) @(posedge clk_sys_i);
		summarize;
	end
endmodule
`default_nettype wire
